// ### src/acd_pkg.sv
/*
 * Shared constants and types for the serial converter command decoder.
 * Assumes a conversion clock domain and a host-driven shift clock domain.
 */
package acd_pkg;

    // Command word, first bit shifted in sits at the top
    localparam int CMD_BITS = 8;
    localparam int RES_BITS = 12;
    localparam int CMD_MODE_POS = 7;
    localparam int CMD_SWAP_POS = 6;
    localparam int CMD_SEL_HI = 5;
    localparam int CMD_SEL_LO = 4;
    localparam int CMD_POL_POS = 3;
    localparam int CMD_ORDER_POS = 2;
    localparam int CMD_LEN_HI = 1;
    localparam int CMD_LEN_LO = 0;

    // Length codes
    localparam logic [1:0] LEN_8 = 2'h0;
    localparam logic [1:0] LEN_OFF = 2'h1;
    localparam logic [1:0] LEN_12 = 2'h2;
    localparam logic [1:0] LEN_16 = 2'h3;

    // Output word lengths in shift clocks
    localparam logic [4:0] WORD_8 = 5'h08;
    localparam logic [4:0] WORD_10 = 5'h0a;
    localparam logic [4:0] WORD_12 = 5'h0c;
    localparam logic [4:0] WORD_16 = 5'h10;
    localparam logic [4:0] IDX_MAX = 5'h1f;

    // Chip select must hold its new level this many conversion clocks
    localparam logic [1:0] DEGLITCH_CYCLES = 2'h2;

    // Offset binary to two's complement
    localparam logic [11:0] SIGN_FLIP = 12'h800;

    // Reset values
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [3:0] CNT_RESET = 4'h0;

    typedef struct packed {
        logic [2:0] pos_channel;
        logic [2:0] neg_channel;
        logic neg_is_common;
    } acd_mux_type;

    typedef struct packed {
        acd_mux_type mux;
        logic unipolar;
        logic msb_first;
    } acd_conv_type;

endpackage

// ### src/acd_cmd_rx.sv
/*
 * Shift clock side: captures the 8-bit command word on rising edges.
 * Assumes sel_active is a settled level from the conversion clock domain
 * that only changes while the shift clock stands still.
 */
`timescale 1ns/1ns
module acd_cmd_rx
    import acd_pkg::*;
(
    input wire logic sclk, // shift clock from the host
    input wire logic sel_active, // recognised selection, low clears the frame
    input wire logic din, // serial command input
    output logic [CMD_BITS-1:0] cmd_reg, // captured command word
    output logic cmd_done_reg // all command bits captured
);

    logic [3:0] bit_cnt_reg;

    // The frame's own select level clears this domain, since the shift clock
    // may stop between frames and no edge can be counted on to do it
    always_ff @(posedge sclk or negedge sel_active) begin
        if (!sel_active) begin
            bit_cnt_reg <= CNT_RESET;
            cmd_reg <= CMD_RESET;
            cmd_done_reg <= 1'b0;
        end else if (bit_cnt_reg != 4'(CMD_BITS)) begin // [R1] [R2]
            cmd_reg <= {cmd_reg[CMD_BITS-2:0], din}; // [R11] [R23]
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(CMD_BITS - 1)) begin
                cmd_done_reg <= 1'b1;
            end
        end
    end

endmodule

// ### src/acd_core.sv
/*
 * Control logic of a serial 12-bit eight-channel converter: chip select
 * deglitcher, command decode, result serialiser and power shutdown.
 * Assumes the analog core pulses conv_done with an offset-binary code on
 * the conversion clock, and the host drives the four-wire link.
 * Shift clock edges are oversampled on the conversion clock, so the
 * shift clock must stay well below a sixth of the conversion clock rate.
 */
`timescale 1ns/1ns
// Summary of operation
// [R1] Command is the first eight shift-clock rises after selection; later input ignored.
// [R2] Output changes on falling shift edges, input sampled on rising; full duplex.
// [R3] Conversion starts at frame end; its result goes out in the next frame.
// [R4] Shift-clock activity is ignored while chip select is high.
// [R5] First four command bits pick the input or pair for the next conversion.
// [R6] Differential mode: select picks a pair; swap bit makes odd channel positive.
// [R7] Single-ended mode: channel is twice select plus swap, against shared return.
// [R8] Fifth bit one gives unipolar straight binary, zero gives bipolar.
// [R9] Bipolar results are two's complement.
// [R10] Sixth bit one gives MSB-first output, zero LSB-first.
// [R11] Bit order affects only the output; command order is fixed.
// [R12] Length code 00 is 8 bits, 10 is 12, 11 is 16, 01 shutdown.
// [R13] The length code sets the length of the word in the same transfer.
// [R14] Host always sends a valid length and matching shift-clock count.
// [R15] Length code 01 puts the device into power shutdown.
// [R16] A shutdown transfer shifts the previous result as a 10-bit word.
// [R17] Host should run a dummy conversion before sending shutdown.
// [R18] Shutdown ends on select going low or a shift clock while selected.
// [R19] Chip select changes shorter than one conversion clock are discarded.
// [R20] A new chip select level is accepted after two conversion clocks.
// [R21] The serial output leaves high impedance once selection is recognised.
// [R22] Deselection is filtered exactly like selection.
// [R23] Command order: mode, swap, select 1, select 0, polarity, order, length.
// [R24] In 16-bit words the four bits after the result are zeros.
module acd_core
    import acd_pkg::*;
(
    input wire logic clock, // conversion clock
    input wire logic reset_n, // synchronous reset
    input wire logic sclk, // shift clock pin
    input wire logic cs_n, // chip select pin, low selects
    input wire logic din, // serial command input pin
    output logic dout_reg, // serial result output value
    output logic dout_oe_reg, // serial output enable, high drives
    input wire logic conv_done, // analog core finished a conversion
    input wire logic [RES_BITS-1:0] conv_code, // offset-binary result from core
    output logic conv_start_reg, // one-cycle conversion request
    output acd_conv_type conv_cfg_reg, // input selection and coding
    output logic power_down_reg // shutdown state
);

    logic cs_meta_reg;
    logic cs_sync_reg;
    logic [1:0] dg_cnt_reg;
    logic sel_active_reg;
    logic sel_prev_reg;
    logic sclk_meta_reg;
    logic sclk_sync_reg;
    logic sclk_prev_reg;
    logic done_meta_reg;
    logic done_sync_reg;
    logic cmd_valid_reg;
    logic [CMD_BITS-1:0] cmd_hold_reg;
    logic [4:0] out_idx_reg;
    logic [RES_BITS-1:0] result_reg;
    logic result_msb_reg;
    logic pending_msb_reg;
    logic [RES_BITS-1:0] frame_result_reg;
    logic frame_msb_reg;
    logic [CMD_BITS-1:0] rx_cmd;
    logic rx_done;
    logic sel_start;
    logic sel_end;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] word_limit;
    logic [4:0] out_idx_next;
    logic [1:0] hold_len_code;

    // Result bit at a position of the outgoing word, zero past its end
    function automatic logic out_bit(input logic [RES_BITS-1:0] res, input logic msb,
                                     input logic [4:0] idx, input logic [4:0] limit);
        logic bit_val;
        bit_val = 1'b0;
        if (idx < limit && idx < 5'(RES_BITS)) begin // [R24]
            bit_val = msb ? res[4'(RES_BITS - 1) - idx[3:0]] : res[idx[3:0]]; // [R10]
        end
        return bit_val;
    endfunction

    function automatic logic [4:0] len_limit(input logic [1:0] code);
        logic [4:0] len;
        len = WORD_16;
        unique case (code) // [R12]
            LEN_8: len = WORD_8;
            LEN_OFF: len = WORD_10; // [R16]
            LEN_12: len = WORD_12;
            LEN_16: len = WORD_16;
        endcase
        return len;
    endfunction

    // Shutdown code test, shared by the conversion and shutdown logic
    function automatic logic len_is_off(input logic [1:0] code);
        return code == LEN_OFF; // [R12] [R15]
    endfunction

    function automatic acd_mux_type mux_decode(input logic [CMD_BITS-1:0] cmd);
        acd_mux_type m;
        logic [2:0] even_ch;
        even_ch = {cmd[CMD_SEL_HI], cmd[CMD_SEL_LO], 1'b0};
        m.neg_is_common = cmd[CMD_MODE_POS];
        if (cmd[CMD_MODE_POS]) begin
            m.pos_channel = even_ch | {2'h0, cmd[CMD_SWAP_POS]}; // [R7]
            m.neg_channel = even_ch;
        end else if (cmd[CMD_SWAP_POS]) begin
            m.pos_channel = even_ch | 3'h1; // [R6]
            m.neg_channel = even_ch;
        end else begin
            m.pos_channel = even_ch;
            m.neg_channel = even_ch | 3'h1; // [R6]
        end
        return m;
    endfunction

    acd_cmd_rx u_cmd_rx (
        .sclk(sclk),
        .sel_active(sel_active_reg), // [R4]
        .din(din),
        .cmd_reg(rx_cmd),
        .cmd_done_reg(rx_done)
    );

    // Pin and command-done synchronisers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_n;
            cs_sync_reg <= cs_meta_reg;
            sclk_meta_reg <= sclk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            done_meta_reg <= rx_done;
            done_sync_reg <= done_meta_reg;
        end
    end

    assign sclk_rise = sclk_sync_reg & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_sync_reg & sclk_prev_reg;

    // Deglitcher: a level must persist two clocks before it is believed,
    // so a blip shorter than one clock never reaches the port logic
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sel_active_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
            dg_cnt_reg <= 2'h0;
        end else begin
            sel_prev_reg <= sel_active_reg;
            if (cs_sync_reg != sel_active_reg) begin
                dg_cnt_reg <= 2'h0; // [R19]
            end else if (dg_cnt_reg == DEGLITCH_CYCLES - 2'h1) begin
                sel_active_reg <= ~cs_sync_reg; // [R20] [R22]
                dg_cnt_reg <= 2'h0;
            end else begin
                dg_cnt_reg <= dg_cnt_reg + 2'h1;
            end
        end
    end

    assign sel_start = sel_active_reg & ~sel_prev_reg;
    assign sel_end = ~sel_active_reg & sel_prev_reg;

    // Command crossing: the word is frozen once done is seen high
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cmd_valid_reg <= 1'b0;
            cmd_hold_reg <= CMD_RESET;
        end else if (sel_start) begin
            cmd_valid_reg <= 1'b0;
        end else if (done_sync_reg && !cmd_valid_reg) begin
            cmd_valid_reg <= 1'b1;
            cmd_hold_reg <= rx_cmd;
        end
    end

    // Until the command is in, only the first eight bits go out anyway
    assign hold_len_code = cmd_hold_reg[CMD_LEN_HI:CMD_LEN_LO];
    assign word_limit = cmd_valid_reg ? len_limit(hold_len_code) : WORD_16; // [R13]
    assign out_idx_next = (out_idx_reg == IDX_MAX) ? out_idx_reg : out_idx_reg + 5'h1;

    // Serialiser
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dout_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
            out_idx_reg <= 5'h00;
        end else if (sel_start) begin
            dout_oe_reg <= 1'b1; // [R21]
            out_idx_reg <= 5'h00;
            dout_reg <= out_bit(result_reg, result_msb_reg, 5'h00, WORD_16);
        end else if (!sel_active_reg) begin
            dout_oe_reg <= 1'b0; // [R4]
            dout_reg <= 1'b0;
        end else if (sclk_fall) begin
            out_idx_reg <= out_idx_next; // [R2]
            dout_reg <= out_bit(frame_result_reg, frame_msb_reg, out_idx_next, word_limit);
        end
    end

    // Frame copy of the result: a conversion that ends while the host is
    // still shifting must not change the word halfway through
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            frame_result_reg <= RESULT_RESET;
            frame_msb_reg <= 1'b1;
        end else if (sel_start) begin
            frame_result_reg <= result_reg; // [R3]
            frame_msb_reg <= result_msb_reg;
        end
    end

    // Conversion request at frame end; a shutdown transfer starts none
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            conv_start_reg <= 1'b0;
            pending_msb_reg <= 1'b1;
            conv_cfg_reg <= '0;
        end else begin
            conv_start_reg <= 1'b0;
            if (sel_end && cmd_valid_reg && !len_is_off(hold_len_code)) begin
                conv_start_reg <= 1'b1; // [R3]
                conv_cfg_reg.mux <= mux_decode(cmd_hold_reg); // [R5]
                conv_cfg_reg.unipolar <= cmd_hold_reg[CMD_POL_POS]; // [R8]
                conv_cfg_reg.msb_first <= cmd_hold_reg[CMD_ORDER_POS];
                pending_msb_reg <= cmd_hold_reg[CMD_ORDER_POS];
            end
        end
    end

    // Shutdown state; entry and wake cannot meet, since wake needs selection
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            power_down_reg <= 1'b0;
        end else if (sel_end && cmd_valid_reg && len_is_off(hold_len_code)) begin
            power_down_reg <= 1'b1; // [R15]
        end else if (sel_start || (sel_active_reg && sclk_rise)) begin
            power_down_reg <= 1'b0; // [R18]
        end
    end

    // Result capture, held for the next frame
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            result_reg <= RESULT_RESET;
            result_msb_reg <= 1'b1;
        end else if (conv_done) begin
            result_reg <= conv_cfg_reg.unipolar ? conv_code : conv_code ^ SIGN_FLIP; // [R9]
            result_msb_reg <= pending_msb_reg; // [R3]
        end
    end

endmodule

// ### verif/acd_core_properties.sv
/* Concurrent checks on the ports of the converter control block.
   Assumes one conversion clock domain and the host keeping the link rules. */
`timescale 1ns/1ns
module acd_core_properties
    import acd_pkg::*;
(
    input wire logic clock, // conversion clock
    input wire logic reset_n, // synchronous reset
    input wire logic sclk, // shift clock
    input wire logic cs_n, // chip select
    input wire logic din, // command input
    input wire logic dout_reg, // serial output
    input wire logic dout_oe_reg, // output enable
    input wire logic conv_done, // core done
    input wire logic [RES_BITS-1:0] conv_code, // core code
    input wire logic conv_start_reg, // start pulse
    input wire acd_conv_type conv_cfg_reg, // conversion setup
    input wire logic power_down_reg // shutdown
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_OE_OFF: assert property (cs_n [*8] |-> !dout_oe_reg)
        else $error("output driven while deselected");
    AST_OE_ON: assert property (!cs_n [*8] |-> dout_oe_reg)
        else $error("output not driven while selected");
    AST_NO_EARLY_OE: assert property ($fell(cs_n) && !dout_oe_reg |=> !dout_oe_reg [*2])
        else $error("selection taken too early");
    AST_START_PULSE: assert property (conv_start_reg |=> !conv_start_reg)
        else $error("start longer than one cycle");
    AST_START_DESEL: assert property (conv_start_reg |-> cs_n && $past(cs_n, 3))
        else $error("start before frame end");
    AST_CFG_CHANGE: assert property ($changed(conv_cfg_reg) |-> conv_start_reg)
        else $error("setup changed without start");
    AST_PD_SET: assert property ($rose(power_down_reg) |-> cs_n && !conv_start_reg)
        else $error("shutdown entered wrongly");
    AST_PD_WAKE: assert property ($fell(power_down_reg) |-> dout_oe_reg || !cs_n)
        else $error("shutdown left without selection");
    AST_DOUT_STEADY: assert property (
        $changed(dout_reg) && dout_oe_reg && $past(dout_oe_reg) |-> !sclk && !$past(sclk, 2))
        else $error("output moved outside low shift phase");
    cover property (conv_start_reg);
    cover property ($rose(power_down_reg));
    cover property ($rose(dout_oe_reg));
endmodule
bind acd_core acd_core_properties i_props (.clock, .reset_n, .sclk, .cs_n, .din, .dout_reg,
    .dout_oe_reg, .conv_done, .conv_code, .conv_start_reg, .conv_cfg_reg, .power_down_reg);

// ### verif/acd_host.sv
/* Host side of the four-wire link: frames, shift clock and command bits.
   Assumes dq is the resolved output wire; the conversion clock paces waits. */
`timescale 1ns/1ns
module acd_host (
    input wire logic clock, // conversion clock
    input wire logic dq, // resolved output wire
    output logic sclk, // shift clock, still between frames except for the pulse driven by glitch
    output logic cs_n, // chip select
    output logic din // command bit
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // Bits move on falls, taken on rises; cycle count equals word length
    task automatic frame(input logic [7:0] cmd, input int n, input logic blip,
                         output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clock) #1 cs_n = 1'b0;
        repeat (8) @(posedge clock);
        #3 din = cmd[7];
        for (int k = 0; k < n; k++) begin
            #40 sclk = 1'b1;
            rx[k] = dq;
            // One-clock deselect blip in mid-frame must not end the frame
            #38 cs_n = blip && (k == 3);
            #10 cs_n = 1'b0;
            #32 sclk = 1'b0;
            // Past the command the line keeps toggling, the device must not care
            din = (k < 7) ? cmd[6-k] : ~din;
            #40;
        end
        #20 cs_n = 1'b1;
        repeat (12) @(posedge clock);
    endtask
    // Select pulse seen by one clock only, then shift clock while deselected
    task automatic glitch();
        @(posedge clock) #1 cs_n = 1'b0;
        @(posedge clock) #1 cs_n = 1'b1;
        #20 sclk = 1'b1;
        #80 sclk = 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ### verif/adc_serial_command_decoder_bench.sv
/* Self-checking bench for the converter control block with a host model.
   Assumes a conversion core that answers a start one cycle later. */
`timescale 1ns/1ns
module adc_serial_command_decoder_bench;
    import acd_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic conv_done = 1'b0;
    logic [RES_BITS-1:0] conv_code = 12'h000;
    logic sclk, cs_n, din, dout_reg, dout_oe_reg, conv_start_reg, power_down_reg;
    acd_conv_type conv_cfg_reg;
    wire dq = dout_oe_reg ? dout_reg : 1'bz;
    int err_total = 0;
    int samples_checked = 0;
    logic [15:0] rx;
    logic [11:0] held = 12'h000;
    logic held_first_bit_order = 1'b1;
    acd_conv_type cfg_exp = '0;
    logic [1:0] lens [3] = '{LEN_8, LEN_12, LEN_16};
    always #5 clock = ~clock;
    always @(posedge clock) begin
        conv_done <= #1 conv_start_reg;
    end
    acd_core i_dut (.clock(clock), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_reg(dout_reg), .dout_oe_reg(dout_oe_reg), .conv_done(conv_done),
        .conv_code(conv_code), .conv_start_reg(conv_start_reg), .conv_cfg_reg(conv_cfg_reg),
        .power_down_reg(power_down_reg));
    acd_host i_host (.clock(clock), .dq(dq), .sclk(sclk), .cs_n(cs_n), .din(din));
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [15:0] word(input logic [11:0] r, input logic m, input int n);
        word = 16'h0000;
        for (int i = 0; i < n && i < 12; i++)
            word[i] = m ? r[11-i] : r[i];
    endfunction
    task automatic step(input logic [7:0] cmd, input logic [11:0] code);
        int n;
        n = (cmd[1:0] == LEN_8) ? 8 : (cmd[1:0] == LEN_12) ? 12 : (cmd[1:0] == LEN_16) ? 16 : 10;
        @(posedge clock) #1 conv_code = code;
        i_host.frame(cmd, n, cmd[1:0] == LEN_16, rx);
        cmp("dout", word(held, held_first_bit_order, n), rx);
        if (cmd[1:0] != LEN_OFF) begin
            held = cmd[CMD_POL_POS] ? code : code ^ SIGN_FLIP;
            held_first_bit_order = cmd[CMD_ORDER_POS];
            cfg_exp = {cmd[5:4], cmd[6], cmd[5:4], cmd[7] ? 1'b0 : ~cmd[6], cmd[7:7], cmd[3:2]};
        end
        cmp("config", {7'h00, cfg_exp}, {7'h00, conv_cfg_reg});
        cmp("shutdown", {15'h0, cmd[1:0] == LEN_OFF}, {15'h0, power_down_reg});
    endtask
    initial begin
        repeat (8) @(posedge clock);
        #1 reset_n = 1'b1;
        i_host.glitch();
        cmp("glitch oe", 16'h0000, {15'h0, dout_oe_reg});
        for (int i = 0; i < 16; i++) begin
            step({i[3:0], ~i[1], i[2] ^ i[0], lens[i % 3]},
                i == 3 ? 12'hfff : 12'h9c3 ^ {3{i[3:0]}});
        end
        step(8'hd5, 12'h456);
        step(8'h2e, 12'h123);
        step(8'h2e, 12'h000);
        conclude();
    end
    initial begin
        #500000;
        err_total++;
        conclude();
    end
endmodule
